// File: core/qdi_if.sv
`timescale 1ns/100ps
interface qdi_if;
	logic sclHostOut;
	logic sclHostOe;
	logic sdaHostOut;
	logic sdaHostOe;
	logic sdaDevOut;
	logic sdaDevOe;
	wire logic scl;
	wire logic sda;

	// Open-drain lines with pull-ups
	assign scl = !(sclHostOe && !sclHostOut);
	assign sda = !((sdaHostOe && !sdaHostOut) || (sdaDevOe && !sdaDevOut));

	modport host (
		output sclHostOut,
		output sclHostOe,
		output sdaHostOut,
		output sdaHostOe,
		input scl,
		input sda
	);
	modport dev (
		output sdaDevOut,
		output sdaDevOe,
		input scl,
		input sda
	);
endinterface : qdi_if

// File: core/qdi_master.sv
`timescale 1ns/100ps
module qdi_master import qdi_pkg::*; #(
	parameter logic [6:0] ADDR7 = {ADDR_UPPER_L, 1'b0},
	parameter int QTR = QTR_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic req,
	input wire logic rnw,
	input wire logic shortWr,
	input wire logic [3:0] cmd,
	input wire logic [CODE_W-1:0] code,
	qdi_if.host bus,
	output logic busy,
	output logic done,
	output logic nack,
	output logic [CODE_W-1:0] rdCode
);
	typedef enum logic [1:0] {
		M_IDLE = 2'h0,
		M_START = 2'h1,
		M_BIT = 2'h2,
		M_STOP = 2'h3
	} qdiHostState_t;

	typedef struct packed {
		qdiHostState_t state;
		logic [QTR_W-1:0] qCnt;
		logic [1:0] ph;
		logic [1:0] byteIdx;
		logic [1:0] lastIdx;
		logic [3:0] bitIdx;
		logic rnw;
		logic [2:0][7:0] bytes;
		logic [7:0] rx;
		logic [CODE_W-1:0] rdCode;
		logic sclOe;
		logic sdaOe;
		logic [1:0] sdaSync;
		logic busy;
		logic done;
		logic nack;
	} qdiHost_t;

	qdiHost_t h_reg;
	qdiHost_t h_next;
	logic tick;
	logic readBit;

	assign bus.sclHostOut = 1'b0;
	assign bus.sdaHostOut = 1'b0;
	assign bus.sclHostOe = h_reg.sclOe;
	assign bus.sdaHostOe = h_reg.sdaOe;
	assign busy = h_reg.busy;
	assign done = h_reg.done;
	assign nack = h_reg.nack;
	assign rdCode = h_reg.rdCode;

	always_comb begin
		h_next = h_reg;
		h_next.done = 1'b0;
		h_next.sdaSync = {h_reg.sdaSync[0], bus.sda};
		tick = h_reg.qCnt == QTR_W'(QTR - 1);
		readBit = h_reg.rnw && (h_reg.byteIdx != 2'h0);
		if (h_reg.state != M_IDLE) begin
			h_next.qCnt = tick ? '0 : QTR_W'(h_reg.qCnt + 1'b1);
			if (tick) begin
				h_next.ph = 2'(h_reg.ph + 2'h1);
			end
		end
		unique case (h_reg.state)
			M_IDLE: begin
				if (req) begin
					h_next.state = M_START;
					h_next.busy = 1'b1;
					h_next.nack = 1'b0;
					h_next.qCnt = '0;
					h_next.ph = 2'h0;
					h_next.byteIdx = 2'h0;
					h_next.bitIdx = 4'h0;
					h_next.rnw = rnw;
					h_next.lastIdx = (rnw || !shortWr) ? 2'h2 : 2'h1;
					h_next.bytes[0] = {ADDR7, rnw};
					h_next.bytes[1] = {cmd, code[9:6]};
					// Extended byte goes out whole; a code word gets zero trailing bits
					h_next.bytes[2] = (cmd == CMD_EXT) ? code[7:0] : {code[5:0], 2'h0};
				end
			end
			M_START: begin
				if (tick && h_reg.ph == 2'h0) begin
					h_next.sdaOe = 1'b1;
				end else if (tick && h_reg.ph == 2'h3) begin
					h_next.sclOe = 1'b1;
					h_next.state = M_BIT;
				end
			end
			M_BIT: begin
				if (tick) begin
					unique case (h_reg.ph)
						2'h0: begin
							// Data changes only with the clock low, never beside its edge
							if (h_reg.bitIdx != 4'h8) begin
								h_next.sdaOe = readBit ? 1'b0 : ~h_reg.bytes[h_reg.byteIdx][3'(3'h7 - h_reg.bitIdx[2:0])];
							end else begin
								h_next.sdaOe = readBit && (h_reg.byteIdx != h_reg.lastIdx);
							end
						end
						2'h1: begin
							h_next.sclOe = 1'b0;
						end
						2'h2: begin
							if (h_reg.bitIdx != 4'h8 && readBit) begin
								h_next.rx = {h_reg.rx[6:0], h_reg.sdaSync[1]};
							end else if (h_reg.bitIdx == 4'h8 && !readBit && h_reg.sdaSync[1]) begin
								h_next.nack = 1'b1;
							end else if (readBit && h_reg.bitIdx == 4'h8 && h_reg.byteIdx == 2'h1) begin
								h_next.rdCode[9:6] = h_reg.rx[3:0];
							end else if (readBit && h_reg.bitIdx == 4'h8) begin
								h_next.rdCode[5:0] = h_reg.rx[7:2];
							end
						end
						2'h3: begin
							h_next.sclOe = 1'b1;
							if (h_reg.bitIdx == 4'h8) begin
								h_next.bitIdx = 4'h0;
								if (h_reg.nack || h_reg.byteIdx == h_reg.lastIdx) begin
									h_next.state = M_STOP;
								end else begin
									h_next.byteIdx = 2'(h_reg.byteIdx + 2'h1);
								end
							end else begin
								h_next.bitIdx = 4'(h_reg.bitIdx + 4'h1);
							end
						end
					endcase
				end
			end
			M_STOP: begin
				if (tick) begin
					unique case (h_reg.ph)
						2'h0: h_next.sdaOe = 1'b1;
						2'h1: h_next.sclOe = 1'b0;
						2'h2: h_next.sdaOe = 1'b0;
						2'h3: begin
							h_next.state = M_IDLE;
							h_next.busy = 1'b0;
							h_next.done = 1'b1;
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			h_reg <= '{state: M_IDLE, sdaSync: 2'h3, default: '0};
		end else begin
			h_reg <= h_next;
		end
	end
endmodule : qdi_master

// File: core/qdi_pkg.sv
package qdi_pkg;
	localparam int NCH = 4;
	localparam int CODE_W = 10;
	localparam int CLK_PERIOD_NS = 10;
	// Bus clock made by the host; 400 kHz
	localparam int SCL_PERIOD_NS = 2500;
	localparam int QTR_CYCLES = SCL_PERIOD_NS / 4 / CLK_PERIOD_NS;
	localparam int QTR_W = 8;
	// Upper six address bits of the two factory variants
	localparam logic [5:0] ADDR_UPPER_L = 6'h1e;
	localparam logic [5:0] ADDR_UPPER_M = 6'h2e;
	// Power-down select encodings
	localparam logic [1:0] PD_AWAKE = 2'h0;
	localparam logic [1:0] PD_FLOAT = 2'h1;
	localparam logic [1:0] PD_1K = 2'h2;
	localparam logic [1:0] PD_100K = 2'h3;
	localparam logic [1:0] PD_RESET = PD_100K;
	localparam logic [9:0] DAC_RESET = 10'h000;
	// Command groups on command_code_bits[3:2]
	localparam logic [1:0] CMD_GRP_LOAD_UPDATE = 2'h0;
	localparam logic [1:0] CMD_GRP_LOAD_INPUT = 2'h1;
	localparam logic [1:0] CMD_GRP_UPDATE_LOAD = 2'h2;
	localparam logic [1:0] CMD_GRP_ALL = 2'h3;
	localparam logic [3:0] CMD_UPDATE = 4'he;
	localparam logic [3:0] CMD_EXT = 4'hf;
	localparam logic [3:0] EXT_ARG = 4'h0;
	// Extended byte: channel bits [3:0], powerdown_select_low [4], powerdown_select_high [5]
	localparam int EXT_PD_POS = 4;
	localparam int SUB_W = 2;
endpackage : qdi_pkg

// File: core/qdi_slave.sv
`timescale 1ns/100ps
module qdi_slave import qdi_pkg::*; #(
	parameter logic [5:0] ADDR_UPPER = ADDR_UPPER_L
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic addrSel,
	qdi_if.dev bus,
	output logic [NCH-1:0][CODE_W-1:0] dacCode,
	output logic [NCH-1:0][1:0] pdMode
);
	typedef enum logic [2:0] {
		L_GATED = 3'h0,
		L_ADDR = 3'h1,
		L_ADDR_ACK = 3'h2,
		L_WR = 3'h3,
		L_WR_ACK = 3'h4,
		L_RD = 3'h5,
		L_RD_ACK = 3'h6
	} qdiLinkState_t;

	typedef struct packed {
		qdiLinkState_t state;
		logic [2:0] bitCnt;
		logic [7:0] shift;
		logic byteSel;
		logic ext;
		logic rnw;
		logic [3:0] cmd;
		logic [3:0] hiCode;
		logic [1:0] rdSel;
		logic rdByte;
		logic sdaOe;
		logic startSeen;
		logic stopSeen;
		logic updTog;
		logic [NCH-1:0][CODE_W-1:0] inp;
		logic [NCH-1:0][CODE_W-1:0] dac;
		logic [NCH-1:0][1:0] pd;
	} qdiLink_t;

	typedef struct packed {
		logic [2:0] updSync;
		logic [NCH-1:0][CODE_W-1:0] dac;
		logic [NCH-1:0][1:0] pd;
	} qdiUser_t;

	qdiLink_t link_reg;
	qdiLink_t link_next;
	qdiUser_t user_reg;
	qdiUser_t user_next;
	logic startTog_reg;
	logic stopTog_reg;
	logic sampBit_reg;
	logic [1:0] addrSync_reg;
	logic [6:0] myAddr;
	logic [CODE_W-1:0] newCode;
	logic [1:0] chan;
	logic [CODE_W-1:0] rdWord;

	assign bus.sdaDevOut = 1'b0;
	assign bus.sdaDevOe = link_reg.sdaOe;
	assign dacCode = user_reg.dac;
	assign pdMode = user_reg.pd;

	// START and STOP are the only events clocked by the data line
	always_ff @(negedge bus.sda or posedge rst) begin
		if (rst) begin
			startTog_reg <= 1'b0;
		end else if (bus.scl) begin
			startTog_reg <= ~startTog_reg;
		end
	end

	always_ff @(posedge bus.sda or posedge rst) begin
		if (rst) begin
			stopTog_reg <= 1'b0;
		end else if (bus.scl) begin
			stopTog_reg <= ~stopTog_reg;
		end
	end

	// Data bit taken while the clock is high; strap synchronised here too
	always_ff @(posedge bus.scl or posedge rst) begin
		if (rst) begin
			sampBit_reg <= 1'b0;
			addrSync_reg <= 2'h0;
		end else begin
			sampBit_reg <= bus.sda;
			addrSync_reg <= {addrSync_reg[0], addrSel};
		end
	end

	assign myAddr = {ADDR_UPPER, addrSync_reg[1]};

	always_comb begin
		link_next = link_reg;
		newCode = {link_reg.hiCode, link_reg.shift[7:SUB_W]};
		chan = link_reg.cmd[1:0];
		rdWord = link_reg.dac[link_reg.rdSel];
		// Toggles stable at least three quarters of a clock before this edge by bus timing
		if (startTog_reg != link_reg.startSeen) begin
			link_next.startSeen = startTog_reg;
			link_next.stopSeen = stopTog_reg;
			link_next.state = L_ADDR;
			link_next.bitCnt = 3'h0;
			link_next.sdaOe = 1'b0;
			link_next.byteSel = 1'b0;
			link_next.ext = 1'b0;
		end else if (stopTog_reg != link_reg.stopSeen) begin
			link_next.stopSeen = stopTog_reg;
			link_next.state = L_GATED;
			link_next.sdaOe = 1'b0;
		end else begin
			unique case (link_reg.state)
				L_GATED: begin
					link_next.sdaOe = 1'b0;
				end
				L_ADDR: begin
					link_next.shift = {link_reg.shift[6:0], sampBit_reg};
					link_next.bitCnt = 3'(link_reg.bitCnt + 3'h1);
					if (link_reg.bitCnt == 3'h7) begin
						link_next.rnw = sampBit_reg;
						link_next.state = L_ADDR_ACK;
						link_next.sdaOe = 1'b1;
					end else if (sampBit_reg != myAddr[3'(3'h6 - link_reg.bitCnt)]) begin
						// Fixed address rejects general call and 10-bit headers
						link_next.state = L_GATED;
					end
				end
				L_ADDR_ACK: begin
					link_next.bitCnt = 3'h0;
					if (link_reg.rnw) begin
						link_next.state = L_RD;
						link_next.rdByte = 1'b0;
						link_next.shift = {4'h0, rdWord[9:6]};
						// First byte opens with four zero pad bits
						link_next.sdaOe = 1'b1;
					end else begin
						link_next.state = L_WR;
						link_next.sdaOe = 1'b0;
					end
				end
				L_WR: begin
					link_next.shift = {link_reg.shift[6:0], sampBit_reg};
					link_next.bitCnt = 3'(link_reg.bitCnt + 3'h1);
					if (link_reg.bitCnt == 3'h7) begin
						link_next.state = L_WR_ACK;
						link_next.sdaOe = 1'b1;
					end
				end
				L_WR_ACK: begin
					// This edge ends the acknowledge clock; a cut-short byte never gets here
					link_next.sdaOe = 1'b0;
					link_next.state = L_WR;
					link_next.bitCnt = 3'h0;
					if (link_reg.ext) begin
						link_next.ext = 1'b0;
						for (int i = 0; i < NCH; i++) begin
							if (link_reg.shift[i]) begin
								link_next.pd[i] = link_reg.shift[EXT_PD_POS +: 2];
							end
						end
						link_next.updTog = ~link_reg.updTog;
					end else if (!link_reg.byteSel) begin
						link_next.cmd = link_reg.shift[7:4];
						link_next.hiCode = link_reg.shift[3:0];
						if (link_reg.shift[7:4] == CMD_UPDATE) begin
							link_next.dac = link_reg.inp;
							link_next.updTog = ~link_reg.updTog;
						end else if (link_reg.shift[7:4] == CMD_EXT) begin
							if (link_reg.shift[3:0] == EXT_ARG) begin
								link_next.ext = 1'b1;
							end
							for (int i = 0; i < NCH; i++) begin
								if (link_reg.shift[3:0] == 4'(1 << i)) begin
									link_next.rdSel = 2'(i);
								end
							end
						end else begin
							link_next.byteSel = 1'b1;
						end
					end else begin
						// Trailing two bits ignored
						link_next.byteSel = 1'b0;
						link_next.updTog = ~link_reg.updTog;
						unique case (link_reg.cmd[3:2])
							CMD_GRP_LOAD_UPDATE: begin
								link_next.dac = link_reg.inp;
								link_next.inp[chan] = newCode;
								link_next.dac[chan] = newCode;
							end
							CMD_GRP_LOAD_INPUT: begin
								link_next.inp[chan] = newCode;
							end
							CMD_GRP_UPDATE_LOAD: begin
								link_next.dac = link_reg.inp;
								link_next.inp[chan] = newCode;
							end
							CMD_GRP_ALL: begin
								for (int i = 0; i < NCH; i++) begin
									link_next.inp[i] = newCode;
									if (!link_reg.cmd[0]) begin
										link_next.dac[i] = newCode;
									end
								end
							end
						endcase
					end
				end
				L_RD: begin
					link_next.bitCnt = 3'(link_reg.bitCnt + 3'h1);
					if (link_reg.bitCnt == 3'h7) begin
						link_next.sdaOe = 1'b0;
						link_next.state = L_RD_ACK;
					end else begin
						link_next.sdaOe = ~link_reg.shift[6];
						link_next.shift = {link_reg.shift[6:0], 1'b0};
					end
				end
				L_RD_ACK: begin
					link_next.bitCnt = 3'h0;
					if (!sampBit_reg && !link_reg.rdByte) begin
						link_next.state = L_RD;
						link_next.rdByte = 1'b1;
						link_next.shift = {rdWord[5:0], 2'h0};
						link_next.sdaOe = ~rdWord[5];
					end else begin
						link_next.state = L_GATED;
						link_next.sdaOe = 1'b0;
					end
				end
				default: begin
					link_next.state = L_GATED;
					link_next.sdaOe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(negedge bus.scl or posedge rst) begin
		if (rst) begin
			link_reg <= '{state: L_GATED, pd: {NCH{PD_RESET}}, dac: {NCH{DAC_RESET}}, default: '0};
		end else begin
			link_reg <= link_next;
		end
	end

	// Register values are copied only after the toggle settles, so they are stable
	always_comb begin
		user_next = user_reg;
		user_next.updSync = {user_reg.updSync[1:0], link_reg.updTog};
		if (user_reg.updSync[2] != user_reg.updSync[1]) begin
			user_next.dac = link_reg.dac;
			user_next.pd = link_reg.pd;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			user_reg <= '{updSync: 3'h0, dac: {NCH{DAC_RESET}}, pd: {NCH{PD_RESET}}};
		end else begin
			user_reg <= user_next;
		end
	end
endmodule : qdi_slave

// File: dv/qdi_checker.sv
`timescale 1ns/100ps
module qdi_checker import qdi_pkg::*; #(
	parameter int QTR = QTR_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic sdaDevOe
);
	localparam int ACK_MAX = 4 * QTR + 2;
	logic sclPast, sdaPast, rdFrame, offBus;
	logic [5:0] fallCnt;
	logic [7:0] oeRun;
	wire logic sclFall = sclPast && !scl;
	wire logic sclRise = !sclPast && scl;
	wire logic startDet = sclPast && scl && sdaPast && !sda;
	wire logic stopDet = sclPast && scl && !sdaPast && sda;

	// Bus lines oversampled by the user clock; clock falls counted from the last START
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclPast <= 1'b1;
			sdaPast <= 1'b1;
			rdFrame <= 1'b0;
			offBus <= 1'b1;
			fallCnt <= 6'h00;
			oeRun <= 8'h00;
		end else begin
			sclPast <= scl;
			sdaPast <= sda;
			oeRun <= !sdaDevOe ? 8'h00 : (oeRun == 8'hff) ? oeRun : oeRun + 8'h01;
			if (startDet) begin
				fallCnt <= 6'h00;
				rdFrame <= 1'b0;
				offBus <= 1'b0;
			end else begin
				if (sclFall && fallCnt != 6'h3f) fallCnt <= fallCnt + 6'h01;
				if (sclRise && fallCnt == 6'h08) rdFrame <= sda;
				if (stopDet || (sclRise && fallCnt == 6'h09 && sda)) offBus <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_oe_scl_low: assert property ($changed(sdaDevOe) |-> !scl)
		else $error("device data drive changed while clock high");
	a_ack_full_slot: assert property ($fell(sdaDevOe) |-> oeRun >= 8'(4 * QTR - 1))
		else $error("device drive shorter than one clock period");
	a_addr_quiet: assert property (fallCnt <= 6'h08 && !sclFall |-> !sdaDevOe)
		else $error("device drove data during address bits");
	a_ack_slot_write: assert property ($rose(sdaDevOe) && !rdFrame |-> fallCnt % 9 == 8)
		else $error("acknowledge started outside ninth clock");
	a_ack_release: assert property ($fell(sdaDevOe) && !rdFrame |-> fallCnt % 9 == 0)
		else $error("acknowledge released at wrong clock");
	a_ack_bounded: assert property ($rose(sdaDevOe) && !rdFrame |-> ##[1:ACK_MAX] !sdaDevOe)
		else $error("acknowledge held too long");
	a_read_ack_wait: assert property (rdFrame && fallCnt == 6'h12 && !sclFall |-> !sdaDevOe)
		else $error("device drove during host acknowledge");
	a_read_pad_zero: assert property (rdFrame && !offBus && fallCnt >= 6'h0a && fallCnt <= 6'h0d && !sclFall |-> sdaDevOe)
		else $error("device read pad bits not driven low");
	a_bus_gated: assert property (offBus |-> !sdaDevOe)
		else $error("device drove data while gated");
endmodule : qdi_checker

// File: dv/tb.sv
`timescale 1ns/100ps
module tb import qdi_pkg::*;;
	typedef struct packed {
		logic rw;
		logic nack;
		logic [CODE_W-1:0] rd;
		logic [NCH-1:0][CODE_W-1:0] dac;
		logic [NCH-1:0][1:0] pd;
	} qdi_note_t;
	localparam int Q = 4;
	logic clk = 1'b0, rst = 1'b0, addrSel = 1'b0, req = 1'b0, rnw = 1'b0, shortWr = 1'b0, done, nack, busy;
	logic [3:0] cmd = 4'h0;
	logic [CODE_W-1:0] code = 10'h000, rdCode;
	logic [NCH-1:0][CODE_W-1:0] dacCode, inpM = '0, dacM = '0;
	logic [NCH-1:0][1:0] pdMode, pdM = {NCH{PD_RESET}};
	qdi_note_t notes[$];
	qdi_note_t mon;
	int badCount = 0, samplesChecked = 0, cycles = 0, rdSel = 0;

	always #5 clk = !clk;

	qdi_if i_qdi_if();
	qdi_slave i_qdi_slave (.clk(clk), .rst(rst), .addrSel(addrSel), .bus(i_qdi_if),
		.dacCode(dacCode), .pdMode(pdMode));
	qdi_master #(.QTR(Q)) i_qdi_master (.clk(clk), .rst(rst), .req(req), .rnw(rnw), .shortWr(shortWr),
		.cmd(cmd), .code(code), .bus(i_qdi_if), .busy(busy), .done(done), .nack(nack), .rdCode(rdCode));
	qdi_checker #(.QTR(Q)) i_qdi_checker (.clk(clk), .rst(rst), .scl(i_qdi_if.scl), .sda(i_qdi_if.sda),
		.sdaDevOe(i_qdi_if.sdaDevOe));

	task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
		samplesChecked++;
		if (e !== g) begin
			badCount++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic summarize();
		$display("Checks %0d mismatches %0d", samplesChecked, badCount);
		if (badCount == 0 && samplesChecked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : summarize

	task automatic tend(input string nm);
		$display("Test %s done", nm);
	endtask : tend

	// Predicts the outcome, notes it, then runs one transaction to done
	task automatic xfer(input logic r, input logic s, input logic [3:0] c, input logic [CODE_W-1:0] d);
		qdi_note_t n;
		int k;
		n.rw = r;
		n.nack = addrSel;
		n.rd = dacM[rdSel];
		if (!addrSel && !r) begin
			if (c == CMD_EXT) begin
				for (k = 0; k < NCH; k++) begin
					if (!s && d[9:6] == EXT_ARG && d[k]) pdM[k] = d[EXT_PD_POS+:2];
					if (s && d[6+k]) rdSel = k;
				end
			end else if (c == CMD_UPDATE) begin
				dacM = inpM;
			end else if (!s) begin
				// A short write of a normal command is an abort and leaves the model alone
				case (c[3:2])
					CMD_GRP_LOAD_UPDATE: begin
						dacM = inpM;
						inpM[c[1:0]] = d;
						dacM[c[1:0]] = d;
					end
					CMD_GRP_LOAD_INPUT: inpM[c[1:0]] = d;
					CMD_GRP_UPDATE_LOAD: begin
						dacM = inpM;
						inpM[c[1:0]] = d;
					end
					default: begin
						inpM = {NCH{d}};
						if (!c[0]) dacM = inpM;
					end
				endcase
			end
		end
		n.dac = dacM;
		n.pd = pdM;
		notes.push_back(n);
		rnw = r;
		shortWr = s;
		cmd = c;
		code = d;
		req = 1'b1;
		@(posedge clk);
		#1 req = 1'b0;
		chk("busy", 40'd1, 40'(busy));
		for (k = 0; k < 2000 && done !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		// A transfer that never ends is a failure, not a skip
		if (done !== 1'b1) begin
			badCount++;
			$display("Error done expected 1 seen %b", done);
		end
		@(posedge clk);
		#1;
	endtask : xfer

	// Results are compared when done appears, oldest note first
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			badCount++;
			$display("Error timeout expected finish seen running");
			summarize();
		end
		if (done === 1'b1) begin
			chk("pending", 40'd1, 40'(notes.size() != 0));
			mon = notes.pop_front();
			chk("busy", 40'd0, 40'(busy));
			chk("nack", 40'(mon.nack), 40'(nack));
			if (mon.rw) chk("rdCode", 40'(mon.rd), 40'(rdCode));
			chk("dacCode", mon.dac, dacCode);
			chk("pdMode", 40'(mon.pd), 40'(pdMode));
		end
	end

	initial begin
		int i;
		void'($urandom(32'h58f0bda1));
		// A real rising edge, so that the bus-clocked flops reset as well
		#1 rst = 1'b1;
		repeat (20) @(posedge clk);
		#1 rst = 1'b0;
		chk("dacCode", {NCH{DAC_RESET}}, dacCode);
		chk("pdMode", 40'({NCH{PD_RESET}}), 40'(pdMode));
		tend("reset");
		for (i = 0; i < 14; i++) xfer(1'b0, 1'b0, 4'(i), 10'($urandom));
		xfer(1'b0, 1'b1, CMD_UPDATE, 10'h3c0);
		tend("commands");
		for (i = 0; i < 4; i++) xfer(1'b0, 1'b0, CMD_EXT, {4'h0, 2'(i), 4'($urandom)});
		tend("power");
		for (i = 0; i < 4; i++) begin
			xfer(1'b0, 1'b1, CMD_EXT, 10'(1 << (6 + i)));
			xfer(1'b1, 1'b0, 4'h0, 10'h000);
		end
		tend("read");
		xfer(1'b0, 1'b1, 4'h0, 10'h155);
		addrSel = 1'b1;
		xfer(1'b0, 1'b0, 4'hc, 10'h2aa);
		addrSel = 1'b0;
		xfer(1'b0, 1'b0, 4'hc, 10'h2aa);
		tend("abort and mismatch");
		repeat (8) xfer(1'b0, 1'b0, 4'($urandom_range(13)), 10'($urandom));
		tend("random");
		repeat (4) @(posedge clk);
		chk("pending", 40'd0, 40'(notes.size()));
		summarize();
	end
endmodule : tb
